// file: core/rco_pkg.sv
// Purpose: shared constants and types for the reference clock output selector
// Assumes: one 25 MHz master clock, registers reached over APB
// Notes:   all offsets are byte addresses of aligned 32-bit words
package rco_pkg;
  localparam longint REF_HZ      = 25000000;  // master clock rate
  localparam int     CLK_NS      = 40;        // master clock period
  // register byte offsets
  localparam logic [7:0] OFF_CFG_A  = 8'h00;  // output A source config
  localparam logic [7:0] OFF_CFG_B  = 8'h04;  // output B source config
  localparam logic [7:0] OFF_REFCFG = 8'h08;  // ref_output_config
  localparam logic [7:0] OFF_FIXED  = 8'h0C;  // fixed free-run clock config
  localparam logic [7:0] OFF_RXFLT  = 8'h10;  // rx_sys_float_select per channel
  localparam logic [7:0] OFF_STATUS = 8'h14;  // read-only block state
  // output source config fields
  localparam int EN_BIT  = 6;  // out_x_enable
  localparam int E1_BIT  = 5;  // ext_x_e1_rate
  localparam int SEL_MSB = 4;  // out_x_source_select [4:0]
  // ref_output_config fields
  localparam int TAP_BIT  = 6;  // jitter_atten_tap_select
  localparam int HOLD_BIT = 5;  // hold_high_on_loss
  localparam int BYP_BIT  = 4;  // synth_bypass
  localparam int FREE_BIT = 3;  // free-run
  localparam int FRQ_MSB  = 2;  // synth_frequency_select [2:0]
  // fixed clock fields
  localparam int FIX_EN_BIT  = 1;
  localparam int FIX_SEL_BIT = 0;
  // reset values and the first external select code
  localparam logic [6:0] CFG_SRC_RESET = 7'h40;  // enabled, channel 0
  localparam logic [6:0] REFCFG_RESET  = 7'h10;  // synthesizer bypassed
  localparam logic [1:0] FIXED_RESET   = 2'h2;   // enabled, 8 kHz
  localparam logic [4:0] SEL_EXT_MIN   = 5'h1D;  // 11101..11111 = external
  // timing
  localparam int     EXT_LOSS_E1  = 8;      // E1 cycles without an edge
  localparam int     MCLK_LOSS_NS = 10000;  // duty watch window
  localparam int     MCLK_WIN     = MCLK_LOSS_NS / CLK_NS;
  localparam int     DUTY_PCT     = 30;     // least high share
  // frequencies in Hz
  localparam longint HZ_8K    = 8000;
  localparam longint HZ_64K   = 64000;
  localparam longint HZ_E1    = 2048000;
  localparam longint HZ_2E1   = 4096000;
  localparam longint HZ_4E1   = 8192000;
  localparam longint HZ_SONET = 19440000;
  localparam longint HZ_32M   = 32768000;
  localparam longint HZ_FIX0  = 8000;
  localparam longint HZ_FIX1  = 2048;

  // phase step of a 32-bit accumulator for a wanted rate
  function automatic logic [31:0] rco_inc(input longint hz);
    return 32'((hz << 32) / REF_HZ);
  endfunction

  typedef enum logic [1:0] {MODE_CLK, MODE_NCO, MODE_HIGH} rco_mode_t;
endpackage

// file: core/rco_reference_clock_output_select.sv
// Purpose: selects and conditions the two reference clock outputs,
//          the fixed clock, the per-channel reference and power-down
// Assumes: ref_clk is the master clock; recovered and external clocks are
//          far slower than ref_clk and are sampled through two flops
// Notes:   derived clocks come from phase accumulators, so they carry one
//          ref_clk period of phase jitter
`timescale 1ns/1ps

module rco_reference_clock_output_select
  import rco_pkg::*;
#(
  parameter int NCH = 22  // line channels
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic [NCH-1:0]   channelRxClockPre,   // ahead of attenuator
  input  wire logic [NCH-1:0]   channelRxClockPost,  // behind attenuator
  input  wire logic [NCH-1:0]   lineLosStatus,       // same clock domain
  input  wire logic             extClockInA,
  input  wire logic             extClockInB,
  input  wire logic             masterClockMonitor,  // master clock pin level
  output logic                  refClockOutA,
  output logic                  refClockOutAOe_n,
  output logic                  refClockOutB,
  output logic                  refClockOutBOe_n,
  output logic                  fixedFreeRunClockOut,
  output logic                  fixedFreeRunClockOutOe_n,
  output logic                  perChannelRefClock,
  output logic                  linePinsOe_n,
  output logic                  txSysIgnore,
  output logic                  txSysOutOe_n,
  output logic [NCH-1:0]        rxSysOutOe_n,
  output logic [NCH-1:0]        rxSysForceLow,
  output logic                  autoReset
);
  // all state of the block
  typedef struct packed {
    logic [NCH-1:0]  s1Pre, s2Pre;    // recovered clock synchronisers
    logic [NCH-1:0]  s1Post, s2Post;
    logic [1:0]      s1Ext, s2Ext, prevExt;
    logic            s1Mclk, s2Mclk;
    logic [6:0]      cfgA, cfgB;      // source configs
    logic [6:0]      refCfg;          // shared output config
    logic [1:0]      fixCfg;
    logic [NCH-1:0]  rxFloat;
    logic [2:0][31:0] acc;            // 0 synth, 1 E1, 2 fixed
    logic [1:0][3:0] extCnt;          // E1 ticks since last edge
    logic [1:0]      extLost;
    rco_mode_t       modeA, modeB;    // applied output modes
    logic            outA, outB, fixOut, per_channel_ref_clock;
    logic [7:0]      winCnt, highCnt;
    logic            mclkLost, autoRst;
    logic            ack, err;
    logic [31:0]     rdata;
  } rco_state_t;

  rco_state_t s;       // registered state
  rco_state_t next_s;  // next state

  localparam rco_state_t RESET_S = '{
    cfgA: CFG_SRC_RESET, cfgB: CFG_SRC_RESET, refCfg: REFCFG_RESET,
    fixCfg: FIXED_RESET, modeA: MODE_CLK, modeB: MODE_CLK, default: '0};

  // working signals of the combinational process
  logic [31:0]     synInc;       // synthesizer phase step
  logic [2:0]      wrap;         // accumulator wrapped this cycle
  logic [1:0]      extEdge;
  logic            synOn, freeRun, hold;
  logic            srcA, srcB, losA, losB;
  logic            staleA, staleB;  // current level is static, no pulse to cut
  rco_mode_t       tgtA, tgtB;   // wanted modes before glitch guard
  logic            lvlA, lvlB;   // wanted source levels
  logic            wrOk, rdHit;
  logic [31:0]     wdat;

  // level of a mode for the given clock and accumulator output
  function automatic logic mode_level(rco_mode_t m, logic clk, logic nco);
    case (m)
      MODE_CLK: return clk;
      MODE_NCO: return nco;
      default:  return 1'b1;
    endcase
  endfunction

  // recovered clock of a select value, tapped per config
  function automatic logic rec_clk(rco_state_t st, logic [4:0] sel);
    if (sel >= 5'(NCH)) return 1'b0;
    return st.refCfg[TAP_BIT] ? st.s2Pre[sel] : st.s2Post[sel];
  endfunction

  // synthesizer frequency code to phase step
  always_comb begin
    case (s.refCfg[FRQ_MSB:0])
      3'h0:    synInc = rco_inc(HZ_8K);
      3'h1:    synInc = rco_inc(HZ_64K);
      3'h2:    synInc = rco_inc(HZ_E1);
      3'h3:    synInc = rco_inc(HZ_2E1);
      3'h4:    synInc = rco_inc(HZ_4E1);
      3'h5:    synInc = rco_inc(HZ_SONET);
      3'h6:    synInc = rco_inc(HZ_32M);
      default: synInc = rco_inc(HZ_E1);
    endcase
  end

  // next state of the whole block
  always_comb begin
    logic [32:0] sum;
    logic [31:0] inc;
    sum = '0;
    inc = '0;
    next_s = s;
    // two-flop synchronisers; first stage read only here
    next_s.s1Pre  = channelRxClockPre;
    next_s.s2Pre  = s.s1Pre;
    next_s.s1Post = channelRxClockPost;
    next_s.s2Post = s.s1Post;
    next_s.s1Ext  = {extClockInB, extClockInA};
    next_s.s2Ext  = s.s1Ext;
    next_s.prevExt = s.s2Ext;
    next_s.s1Mclk = masterClockMonitor;
    next_s.s2Mclk = s.s1Mclk;
    extEdge = s.s2Ext & ~s.prevExt;

    synOn   = ~s.refCfg[BYP_BIT];
    freeRun = synOn & s.refCfg[FREE_BIT];
    hold    = s.refCfg[HOLD_BIT];

    // phase accumulators, all locked to the master clock
    for (int i = 0; i < 3; i++) begin
      case (i)
        0:       inc = synOn ? synInc : rco_inc(HZ_E1);
        1:       inc = rco_inc(HZ_E1);
        default: inc = s.fixCfg[FIX_SEL_BIT] ? rco_inc(HZ_FIX1)
                                             : rco_inc(HZ_FIX0);
      endcase
      sum = {1'b0, s.acc[i]} + {1'b0, inc};
      next_s.acc[i] = sum[31:0];
      wrap[i] = sum[32];
    end
    next_s.per_channel_ref_clock   = s.acc[1][31];
    next_s.fixOut = s.acc[2][31];

    // external clock watch, counted in master-derived E1 ticks
    for (int k = 0; k < 2; k++) begin
      if (extEdge[k]) begin
        next_s.extCnt[k]  = '0;
        next_s.extLost[k] = 1'b0;
      end else if (wrap[1] && s.extCnt[k] <= 4'(EXT_LOSS_E1)) begin
        next_s.extCnt[k] = s.extCnt[k] + 4'h1;
      end
      if (!extEdge[k] && s.extCnt[k] > 4'(EXT_LOSS_E1))
        next_s.extLost[k] = 1'b1;
    end
    // loss only counts in E1 mode
    if (!s.cfgA[E1_BIT]) next_s.extLost[0] = 1'b0;
    if (!s.cfgB[E1_BIT]) next_s.extLost[1] = 1'b0;

    // output A wanted mode
    srcA = s.cfgA[SEL_MSB:0] >= SEL_EXT_MIN;
    losA = !srcA && s.cfgA[SEL_MSB:0] < 5'(NCH)
           && lineLosStatus[s.cfgA[SEL_MSB:0]];
    if (freeRun)
      tgtA = MODE_NCO;
    else if (srcA && s.extLost[0])
      tgtA = MODE_HIGH;
    else if (losA)
      tgtA = hold ? MODE_HIGH : MODE_NCO;
    else if (!srcA && s.cfgA[SEL_MSB:0] >= 5'(NCH))
      tgtA = MODE_HIGH;                                     // unused codes
    else
      tgtA = synOn ? MODE_NCO : MODE_CLK;
    lvlA = srcA ? s.s2Ext[0] : rec_clk(s, s.cfgA[SEL_MSB:0]);

    // output B wanted mode, no synthesizer here
    srcB = s.cfgB[SEL_MSB:0] >= SEL_EXT_MIN;
    losB = !srcB && s.cfgB[SEL_MSB:0] < 5'(NCH)
           && lineLosStatus[s.cfgB[SEL_MSB:0]];
    if ((srcB && s.extLost[1]) || losB)
      tgtB = hold ? MODE_HIGH : MODE_NCO;
    else if (!srcB && s.cfgB[SEL_MSB:0] >= 5'(NCH))
      tgtB = MODE_HIGH;
    else
      tgtB = MODE_CLK;
    lvlB = srcB ? s.s2Ext[1] : rec_clk(s, s.cfgB[SEL_MSB:0]);

    // switch only while the output is low and the new level is low or the new mode is MODE_HIGH, so no
    // shortened pulse escapes; a static high or a stopped source has no
    // pulse to cut, so leaving it only waits for the new level to be low
    staleA = s.modeA == MODE_HIGH || (srcA && s.extLost[0]);
    staleB = s.modeB == MODE_HIGH || (srcB && s.extLost[1]);
    if (tgtA != s.modeA && (!s.outA || staleA) &&
        (tgtA == MODE_HIGH || !mode_level(tgtA, lvlA, s.acc[0][31])))
      next_s.modeA = tgtA;
    if (tgtB != s.modeB && (!s.outB || staleB) &&
        (tgtB == MODE_HIGH || !mode_level(tgtB, lvlB, s.acc[1][31])))
      next_s.modeB = tgtB;
    next_s.outA = mode_level(s.modeA, lvlA, s.acc[0][31]);
    next_s.outB = mode_level(s.modeB, lvlB, s.acc[1][31]);

    // master clock duty watch over fixed windows
    next_s.autoRst = 1'b0;
    if (s.winCnt == 8'(MCLK_WIN - 1)) begin
      next_s.winCnt  = '0;
      next_s.highCnt = '0;
      if (32'(s.highCnt) * 100 < 32'(DUTY_PCT * MCLK_WIN))
        next_s.mclkLost = 1'b1;
      else if (s.mclkLost) begin
        next_s.mclkLost = 1'b0;
        next_s.autoRst  = 1'b1;
      end
    end else begin
      next_s.winCnt  = s.winCnt + 8'h1;
      next_s.highCnt = s.highCnt + 8'(s.s2Mclk);
    end

    // APB: answer registered in setup, write lands at access edge
    rdHit = 1'b1;
    case (paddr)
      OFF_CFG_A:  next_s.rdata = {25'h0, s.cfgA};
      OFF_CFG_B:  next_s.rdata = {25'h0, s.cfgB};
      OFF_REFCFG: next_s.rdata = {25'h0, s.refCfg};
      OFF_FIXED:  next_s.rdata = {30'h0, s.fixCfg};
      OFF_RXFLT:  next_s.rdata = 32'(s.rxFloat);
      OFF_STATUS: next_s.rdata = {24'h0, 2'(s.modeB), 2'(s.modeA),
                                  1'b0, s.mclkLost, s.extLost};
      default: begin
        next_s.rdata = '0;
        rdHit = 1'b0;
      end
    endcase
    next_s.ack = psel && !penable;
    next_s.err = !rdHit;
    wrOk = psel && penable && s.ack && pwrite && rdHit;
    wdat = pwdata;
    if (wrOk) begin
      case (paddr)
        OFF_CFG_A:  next_s.cfgA   = wdat[6:0];
        OFF_CFG_B:  next_s.cfgB   = wdat[6:0];
        OFF_REFCFG: next_s.refCfg = wdat[6:0];
        OFF_FIXED:  next_s.fixCfg = wdat[1:0];
        OFF_RXFLT:  next_s.rxFloat = wdat[NCH-1:0];
        default:    next_s.refCfg = s.refCfg;  // status is read-only
      endcase
    end
  end

  // one register stage; the automatic reset clears everything too
  always_ff @(posedge ref_clk) begin
    if (rst || s.autoRst) begin
      s <= RESET_S;
    end else begin
      s <= next_s;
    end
  end

  // outputs
  assign pready  = s.ack;
  assign pslverr = s.ack & s.err;
  assign prdata  = s.rdata;
  assign refClockOutA     = s.outA;
  assign refClockOutAOe_n = ~s.cfgA[EN_BIT];
  assign refClockOutB     = s.outB;
  assign refClockOutBOe_n = ~s.cfgB[EN_BIT];
  assign fixedFreeRunClockOut     = s.fixOut;
  assign fixedFreeRunClockOutOe_n = ~s.fixCfg[FIX_EN_BIT];
  assign perChannelRefClock = s.per_channel_ref_clock;
  assign linePinsOe_n  = s.mclkLost;
  assign txSysIgnore   = s.mclkLost;
  assign txSysOutOe_n  = s.mclkLost;
  assign rxSysOutOe_n  = {NCH{s.mclkLost}} & s.rxFloat;
  assign rxSysForceLow = {NCH{s.mclkLost}} & ~s.rxFloat;
  assign autoReset     = s.autoRst;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  out_disable_a: assert property (psel && penable && pready && pwrite
      && paddr == OFF_CFG_A && !pwdata[EN_BIT] |=> refClockOutAOe_n)
    else $error("output A still driven after disable");
  synth_reset_a: assert property (disable iff (1'b0)
      rst |=> s.refCfg[BYP_BIT] && !s.refCfg[FREE_BIT])
    else $error("synthesizer not bypassed after reset");
  los_high_a: assert property (losA && hold && !freeRun
      |-> tgtA == MODE_HIGH)
    else $error("output A not held high on line loss");
  los_lock_a: assert property (losB && !hold |-> tgtB == MODE_NCO)
    else $error("output B not master locked on line loss");
  ext_count_a: assert property ($rose(s.extLost[0])
      |-> $past(s.extCnt[0]) == 4'(EXT_LOSS_E1 + 1))
    else $error("external loss flagged at wrong count");
  ext_return_a: assert property (s.extLost[1] && extEdge[1]
      |=> !s.extLost[1] && s.extCnt[1] == 4'h0)
    else $error("external loss not cleared by edge");
  pwr_down_a: assert property (s.mclkLost
      |-> linePinsOe_n && txSysOutOe_n && txSysIgnore)
    else $error("pins not floated on master clock loss");
  rx_float_a: assert property (s.mclkLost
      |-> (rxSysOutOe_n ^ rxSysForceLow) == {NCH{1'b1}})
    else $error("rx output neither floated nor low");
  auto_reset_a: assert property (s.autoRst |=> !s.mclkLost
      && s.refCfg == REFCFG_RESET)
    else $error("no automatic reset after clock return");
  no_runt_a: assert property (s.modeA != $past(s.modeA) && !$past(s.autoRst)
      |-> !$past(s.outA) || $past(s.modeA) == MODE_HIGH || $past(srcA && s.extLost[0]))
    else $error("output A switched while high");
  per_channel_ref_clock_rate_a: assert property (disable iff (rst || s.autoRst)
      $rose(perChannelRefClock)
      |-> ##[5:7] $fell(perChannelRefClock))
    else $error("per-channel reference half period off");

  free_run_c:  cover property (freeRun && s.modeA == MODE_NCO);
  ext_lost_c:  cover property ($rose(s.extLost[1]));
  mclk_loss_c: cover property (s.mclkLost ##[1:300] s.autoRst);
endmodule

// file: test/rco_clock_sources.sv
// Purpose: far-side clock sources: recovered line clocks, external clocks, master pin
// Assumes: recovered clocks are slow against ref_clk and unrelated in phase
// Notes:   each channel has its own rate so a wrong pick shows as a wrong edge count
`timescale 1ns/1ps
module rco_clock_sources #(
  parameter int NCH = 22  // line channels
) (
  input  wire logic           extRunA,     // external A present
  input  wire logic           extRunB,     // external B present
  input  wire logic           masterOk,    // master clock present
  output logic [NCH-1:0]      rxClockPre,  // ahead of attenuator
  output logic [NCH-1:0]      rxClockPost, // behind attenuator
  output logic                extClockA,
  output logic                extClockB,
  output logic                masterLevel
);
  // per channel: pre period 10+c cycles, post period 20+c cycles of 40 ns
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    initial begin
      rxClockPre[c] = 1'b0;
      #7;
      forever #(200 + 20 * c) rxClockPre[c] = ~rxClockPre[c];
    end
    initial begin
      rxClockPost[c] = 1'b0;
      #13;
      forever #(400 + 20 * c) rxClockPost[c] = ~rxClockPost[c];
    end
  end
  // external E1 clocks stand still while absent
  initial begin
    extClockA = 1'b0;
    extClockB = 1'b0;
    #3;
    forever begin
      #244;
      if (extRunA) extClockA = ~extClockA;
      if (extRunB) extClockB = ~extClockB;
    end
  end
  // master pin: 50 percent duty while present, stuck low when lost
  initial begin
    masterLevel = 1'b0;
    forever begin
      #100;
      masterLevel = masterOk ? ~masterLevel : 1'b0;
    end
  end
endmodule

// file: test/rco_reference_clock_output_select_tb.sv
// Purpose: self-checking bench for the reference clock output selector
// Assumes: zero-wait APB slave, far-side clocks from rco_clock_sources
// Notes:   clock rates are judged by counting rising edges over a window
`timescale 1ns/1ps
module rco_reference_clock_output_select_tb;
  import rco_pkg::*;
  logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [21:0] preClk, postClk, lineLos, rxOe_n, rxLow;
  logic        extA, extB, mLevel, extRunA, extRunB, masterOk;
  logic        outA, outAOe_n, outB, outBOe_n, fixClk, fixOe_n, chRef;
  logic        lineOe_n, txIgnore, txOe_n, autoReset;
  int          mismatches, n_tests;

  rco_clock_sources i_rco_clock_sources (.extRunA(extRunA), .extRunB(extRunB),
    .masterOk(masterOk), .rxClockPre(preClk), .rxClockPost(postClk),
    .extClockA(extA), .extClockB(extB), .masterLevel(mLevel));
  rco_reference_clock_output_select i_rco_reference_clock_output_select (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .channelRxClockPre(preClk), .channelRxClockPost(postClk), .lineLosStatus(lineLos),
    .extClockInA(extA), .extClockInB(extB), .masterClockMonitor(mLevel),
    .refClockOutA(outA), .refClockOutAOe_n(outAOe_n), .refClockOutB(outB),
    .refClockOutBOe_n(outBOe_n), .fixedFreeRunClockOut(fixClk),
    .fixedFreeRunClockOutOe_n(fixOe_n), .perChannelRefClock(chRef),
    .linePinsOe_n(lineOe_n), .txSysIgnore(txIgnore), .txSysOutOe_n(txOe_n),
    .rxSysOutOe_n(rxOe_n), .rxSysForceLow(rxLow), .autoReset(autoReset));

  // clock source
  initial begin
    ref_clk = 1'b0;
    forever #(CLK_NS / 2) ref_clk = ~ref_clk;
  end
  // watchdog sized only a little above the whole sequence
  initial begin
    repeat (110000) @(posedge ref_clk);
    mismatches++;
    print_verdict();
  end

  task automatic print_verdict();
    if (mismatches == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // compare a design value, unknowns never match
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // compare an edge count within a tolerance
  task automatic check_cnt(input int got, input int exp, input int tol);
    n_tests++;
    if (got < exp - tol || got > exp + tol) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %0d edges, expected %0d", $time, got, exp);
    end
  endtask
  // one APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // no wait-state count assumed; only the watchdog ends a hang
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic expErr);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    check_val(q, exp);
    check_val({31'h0, e}, {31'h0, expErr});
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return outA;
      1: return outB;
      2: return fixClk;
      default: return chRef;
    endcase
  endfunction
  // settle, count rising edges over cyc cycles, compare
  task automatic measure(input int s, input int cyc, input int exp, input int tol);
    logic prev;
    int   n;
    repeat (400) @(posedge ref_clk);
    n = 0;
    prev = pick(s);
    repeat (cyc) begin
      @(posedge ref_clk);
      if (pick(s) === 1'b1 && prev === 1'b0) n++;
      prev = pick(s);
    end
    check_cnt(n, exp, tol);
  endtask
  task automatic static_high(input int s);
    measure(s, 300, 0, 0);
    check_val({31'h0, pick(s)}, 32'h1);
  endtask
  function automatic longint hz_of(input int code);
    case (code)
      0: return HZ_8K;
      1: return HZ_64K;
      2: return HZ_E1;
      3: return HZ_2E1;
      4: return HZ_4E1;
      5: return HZ_SONET;
      6: return HZ_32M;
      default: return HZ_E1;
    endcase
  endfunction
  // edges that ref_clk sampling can see in cyc cycles: rates above half
  // of ref_clk fold back, so 19.44 and 32.768 MHz show as their aliases
  function automatic int seen_edges(input int code, input int cyc);
    longint f;
    f = hz_of(code) % REF_HZ;
    if (2 * f > REF_HZ) f = REF_HZ - f;
    return int'(longint'(cyc) * f / REF_HZ);
  endfunction

  task automatic t_reset();
    rd_chk(OFF_CFG_A, 32'h40, 1'b0);
    rd_chk(OFF_CFG_B, 32'h40, 1'b0);
    rd_chk(OFF_REFCFG, 32'h10, 1'b0);
    rd_chk(OFF_FIXED, 32'h2, 1'b0);
    rd_chk(OFF_RXFLT, 32'h0, 1'b0);
    rd_chk(8'h18, 32'h0, 1'b1);
    check_val({30'h0, outAOe_n, outBOe_n}, 32'h0);
    wr(OFF_CFG_A, 32'h00);
    repeat (4) @(posedge ref_clk);
    check_val({30'h0, outAOe_n, outBOe_n}, 32'h2);
    wr(OFF_CFG_A, 32'h40);
  endtask
  // channel pick and attenuator tap, A and B on different channels
  task automatic t_channels();
    int chs[3] = '{0, 9, 21};
    for (int i = 0; i < 3; i++) begin
      for (int tap = 0; tap < 2; tap++) begin
        wr(OFF_CFG_A, 32'h40 | chs[i]);
        wr(OFF_CFG_B, 32'h40 | (21 - chs[i]));
        wr(OFF_REFCFG, 32'h10 | (tap << TAP_BIT));
        measure(0, 1000, 1000 / ((tap == 1 ? 10 : 20) + chs[i]), 2);
        measure(1, 1000, 1000 / ((tap == 1 ? 10 : 20) + 21 - chs[i]), 2);
      end
    end
  endtask
  // synthesizer codes, then free run on allowed codes only
  task automatic t_synth();
    int codes[8] = '{1, 2, 3, 4, 5, 6, 7, 0};
    int fr[4] = '{1, 2, 4, 5};
    int cyc;
    wr(OFF_CFG_A, 32'h40);
    for (int i = 0; i < 8; i++) begin
      cyc = codes[i] == 0 ? 6250 : 2500;
      wr(OFF_REFCFG, codes[i]);
      if (codes[i] >= 5) measure(0, cyc, seen_edges(codes[i], cyc), 2);
      else measure(0, cyc, int'(longint'(cyc) * hz_of(codes[i]) / REF_HZ), 2);
    end
    wr(OFF_CFG_A, 32'h55);
    for (int i = 0; i < 4; i++) begin
      wr(OFF_REFCFG, 32'h08 | fr[i]);
      measure(0, 2500, seen_edges(fr[i], 2500), 2);
    end
  endtask
  // external sources, their loss and the return of source A
  task automatic t_external();
    for (int s = 29; s < 32; s++) begin
      wr(OFF_REFCFG, 32'h10);
      wr(OFF_CFG_A, 32'h60 | s);
      wr(OFF_CFG_B, 32'h60 | s);
      measure(0, 1000, 81, 2);
      measure(1, 1000, 81, 2);
    end
    extRunA <= 1'b0;
    static_high(0);
    rd_chk(OFF_STATUS, 32'h21, 1'b0);
    wr(OFF_REFCFG, 32'h0A);
    measure(0, 1000, 81, 2);
    extRunA <= 1'b1;
    wr(OFF_REFCFG, 32'h10);
    measure(0, 1000, 81, 2);
    extRunB <= 1'b0;
    wr(OFF_REFCFG, 32'h30);
    static_high(1);
    wr(OFF_REFCFG, 32'h10);
    measure(1, 1000, 81, 2);
    extRunB <= 1'b1;
  endtask
  // line loss on the selected channel only
  task automatic t_los();
    wr(OFF_REFCFG, 32'h30);
    wr(OFF_CFG_A, 32'h43);
    wr(OFF_CFG_B, 32'h43);
    lineLos <= 22'h10;
    measure(0, 1000, 43, 2);
    lineLos <= 22'h18;
    static_high(0);
    static_high(1);
    wr(OFF_REFCFG, 32'h10);
    measure(0, 1000, 81, 2);
    measure(1, 1000, 81, 2);
    lineLos <= 22'h0;
    measure(0, 1000, 43, 2);
  endtask
  task automatic t_fixed();
    measure(2, 6250, 2, 1);
    wr(OFF_FIXED, 32'h3);
    measure(2, 12500, 1, 1);
    wr(OFF_FIXED, 32'h0);
    repeat (2) @(posedge ref_clk);
    check_val({31'h0, fixOe_n}, 32'h1);
    measure(3, 1000, 81, 2);
  endtask
  // master loss power-down, then automatic reset on return
  task automatic t_master();
    int n;
    wr(OFF_RXFLT, 32'h155555);
    wr(OFF_CFG_A, 32'h45);
    masterOk <= 1'b0;
    n = 0;
    while (lineOe_n !== 1'b1 && n < 1000) begin
      @(posedge ref_clk);
      n++;
    end
    check_val({29'h0, lineOe_n, txIgnore, txOe_n}, 32'h7);
    check_val({10'h0, rxOe_n}, 32'h155555);
    check_val({10'h0, rxLow}, 32'h2AAAAA);
    masterOk <= 1'b1;
    n = 0;
    while (autoReset !== 1'b1 && n < 1000) begin
      @(posedge ref_clk);
      n++;
    end
    check_val({31'h0, autoReset}, 32'h1);
    repeat (3) @(posedge ref_clk);
    rd_chk(OFF_CFG_A, 32'h40, 1'b0);
    rd_chk(OFF_RXFLT, 32'h0, 1'b0);
  endtask

  // main sequence
  initial begin
    mismatches = 0;
    n_tests = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    lineLos = 22'h0;
    extRunA = 1'b1;
    extRunB = 1'b1;
    masterOk = 1'b1;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_channels();
    t_synth();
    t_external();
    t_los();
    t_fixed();
    t_master();
    print_verdict();
  end
endmodule
